// *** rtl/rtc_time_control_and_counters.sv ***
// Time-of-day control and BCD seconds, minutes and hours counters.
// Assumes a register port behind the serial host port and a 32 kHz
// enable; the calendar counter and status register live elsewhere.
//
// Operation
// - Writing 1 to the time update request starts halting the time counter.
// - The time counter counts as halted only once the acknowledge flag is set.
// - Writing 0 to the time update request resumes counting from registers.
// - The calendar request halts the calendar the same way, 0 restarts it.
// - The time event select picks minute, hour, midnight or noon events.
// - The calendar select picks Monday, first of month or first of January.
// - Seconds count 0 to 59 in BCD.
// - Minutes count 0 to 59 in BCD.
// - Hours are BCD, 1 to 12 in 12-hour format and 0 to 23 in 24-hour.
// - The meridiem bit shows and sets morning or afternoon in 12-hour mode.
module rtc_time_control_and_counters
    import rtc_pkg::*;
#(
    parameter int OSC_TICKS_PER_SEC = OSC_HZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic oscTick,
    input wire rtc_pkg::reg_req_s regReq,
    input wire rtc_pkg::flag_clear_s flagClear,
    input wire rtc_pkg::cal_status_s calStatus,
    output logic [7:0] regRdData,
    output logic updateAck,
    output logic timeEventFlag,
    output logic calendarEventFlag,
    output logic dayRollover,
    output logic calendarHalted
);
    import rtc_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic softRst;
        logic hour12;
        logic [6:0] sec;
        logic [6:0] min;
        logic [6:0] hour;
        upd_e upd;
        logic ack;
        logic timeEv;
        logic calendar_event_flag;
        logic dayRoll;
        logic calCheck;
        logic calHalt;
        logic [7:0] rdData;
    } rtc_state_s;

    rtc_state_s s_reg;
    rtc_state_s s_next;
    logic secTick;
    logic timeHalted;
    logic anyReq;

    function automatic logic [6:0] bcd_inc(input logic [6:0] v);
        if (v[3:0] == BCD_NINE) begin
            return {v[6:4] + 3'h1, 4'h0};
        end
        return {v[6:4], v[3:0] + 4'h1};
    endfunction

    assign anyReq = s_reg.ctrl[CTRL_TIME_REQ_BIT]
        | s_reg.ctrl[CTRL_CAL_REQ_BIT];
    // Stopped only after the acknowledge state is reached
    assign timeHalted = (s_reg.upd == UPD_HALT)
        & s_reg.ctrl[CTRL_TIME_REQ_BIT];

    rtc_second_divider #(
        .DIV(OSC_TICKS_PER_SEC)
    ) u_div (
        .clk(clk),
        .rst_n(rst_n),
        .hold(timeHalted | s_reg.softRst),
        .oscTick(oscTick),
        .secTick(secTick)
    );

    always_comb begin
        logic minCarry;
        logic hourCarry;
        logic midnight;
        logic noon;
        logic timeEvent;
        logic calEvent;
        logic [5:0] h;
        logic pm;
        minCarry = 1'b0;
        hourCarry = 1'b0;
        midnight = 1'b0;
        noon = 1'b0;
        timeEvent = 1'b0;
        calEvent = 1'b0;
        h = s_reg.hour[5:0];
        pm = s_reg.hour[MERIDIEM_BIT];
        s_next = s_reg;
        s_next.dayRoll = 1'b0;
        s_next.calCheck = s_reg.dayRoll;

        // Seconds, minutes, hours advance
        if (secTick && !timeHalted) begin
            if (s_reg.sec == BCD_LAST_MIN_SEC) begin
                s_next.sec = TIME_RESET;
                minCarry = 1'b1;
            end else begin
                s_next.sec = bcd_inc(s_reg.sec);
            end
            if (minCarry) begin
                if (s_reg.min == BCD_LAST_MIN_SEC) begin
                    s_next.min = TIME_RESET;
                    hourCarry = 1'b1;
                end else begin
                    s_next.min = bcd_inc(s_reg.min);
                end
            end
            if (hourCarry) begin
                if (s_reg.hour12) begin
                    // 12 wraps to 1; 11 to 12 flips the half of day
                    if (h == BCD_NOON) begin
                        h = BCD_ONE;
                    end else if (h == BCD_ELEVEN) begin
                        h = BCD_NOON;
                        pm = ~pm;
                        midnight = ~pm;
                        noon = pm;
                    end else begin
                        h = 6'(bcd_inc({1'b0, h}));
                    end
                end else begin
                    if (h == BCD_LAST_HOUR_24) begin
                        h = '0;
                        midnight = 1'b1;
                    end else begin
                        h = 6'(bcd_inc({1'b0, h}));
                        noon = (h == BCD_NOON);
                    end
                    pm = 1'b0;
                end
                s_next.hour = {pm, h};
            end
            // Last tick before the halt still counts
            if (s_reg.upd == UPD_WAIT) begin
                s_next.upd = UPD_HALT;
            end
        end

        case (s_reg.ctrl[CTRL_TIME_SEL_LSB +: 2])
            TSEL_MINUTE: timeEvent = minCarry;
            TSEL_HOUR: timeEvent = hourCarry;
            TSEL_MIDNIGHT: timeEvent = midnight;
            TSEL_NOON: timeEvent = noon;
            default: timeEvent = 1'b0;
        endcase
        s_next.dayRoll = midnight;

        // Calendar landmarks are judged after the calendar has advanced
        if (s_reg.calCheck) begin
            case (s_reg.ctrl[CTRL_CAL_SEL_LSB +: 2])
                CSEL_WEEK: calEvent = calStatus.isMonday;
                CSEL_MONTH: calEvent = calStatus.firstOfMonth;
                default: calEvent = calStatus.firstOfJanuary;
            endcase
        end

        // Update request handshake
        case (s_reg.upd)
            UPD_RUN: begin
                if (anyReq) begin
                    s_next.upd = UPD_WAIT;
                end
            end
            UPD_WAIT: begin
                if (!anyReq) begin
                    s_next.upd = UPD_RUN;
                end
            end
            UPD_HALT: begin
                if (!anyReq) begin
                    s_next.upd = UPD_RUN;
                end
            end
            default: s_next.upd = UPD_RUN;
        endcase

        // Flags: a set in the same cycle beats a clear
        if (flagClear.ack || s_next.upd != UPD_HALT) begin
            s_next.ack = 1'b0;
        end
        if (s_reg.upd != UPD_HALT && s_next.upd == UPD_HALT) begin
            s_next.ack = 1'b1;
        end
        if (flagClear.timeEvent) begin
            s_next.timeEv = 1'b0;
        end
        if (timeEvent) begin
            s_next.timeEv = flagClear.timeEvent | ~s_reg.timeEv;
        end
        if (flagClear.calEvent) begin
            s_next.calendar_event_flag = 1'b0;
        end
        if (calEvent) begin
            s_next.calendar_event_flag = flagClear.calEvent | ~s_reg.calendar_event_flag;
        end
        s_next.calHalt = (s_next.upd == UPD_HALT)
            & s_next.ctrl[CTRL_CAL_REQ_BIT];

        // Register writes; the host keeps the group order and halt
        if (regReq.write) begin
            case (regReq.addr)
                OFS_CONTROL: begin
                    s_next.ctrl = regReq.wrData & CTRL_WRITE_MASK;
                end
                OFS_SOFT_RESET: begin
                    s_next.softRst = regReq.wrData[SOFT_RESET_BIT];
                end
                OFS_HOUR_FORMAT: begin
                    s_next.hour12 = regReq.wrData[HOUR_FORMAT_BIT];
                end
                OFS_SECONDS: s_next.sec = regReq.wrData[6:0];
                OFS_MINUTES: s_next.min = regReq.wrData[6:0];
                OFS_HOURS: s_next.hour = regReq.wrData[6:0];
                default: ;
            endcase
        end

        // Register reads, answered one cycle later
        if (regReq.read) begin
            case (regReq.addr)
                OFS_CONTROL: s_next.rdData = s_reg.ctrl;
                OFS_SOFT_RESET: begin
                    s_next.rdData = {s_reg.softRst, 7'h00};
                end
                OFS_HOUR_FORMAT: s_next.rdData = {7'h00, s_reg.hour12};
                OFS_SECONDS: s_next.rdData = {1'b0, s_reg.sec};
                OFS_MINUTES: s_next.rdData = {1'b0, s_reg.min};
                OFS_HOURS: s_next.rdData = {1'b0, s_reg.hour};
                OFS_STATUS: begin
                    s_next.rdData = 8'h00;
                    s_next.rdData[STAT_ACK_BIT] = s_reg.ack;
                    s_next.rdData[STAT_TIME_EV_BIT] = s_reg.timeEv;
                    s_next.rdData[STAT_CAL_EV_BIT] = s_reg.calendar_event_flag;
                end
                default: s_next.rdData = 8'h00;
            endcase
        end

        // Soft reset clears everything but itself and the read latch
        if (s_reg.softRst) begin
            s_next.ctrl = CTRL_RESET;
            s_next.hour12 = 1'b0;
            s_next.sec = TIME_RESET;
            s_next.min = TIME_RESET;
            s_next.hour = TIME_RESET;
            s_next.upd = UPD_RUN;
            s_next.ack = 1'b0;
            s_next.timeEv = 1'b0;
            s_next.calendar_event_flag = 1'b0;
            s_next.dayRoll = 1'b0;
            s_next.calCheck = 1'b0;
            s_next.calHalt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '{ctrl: CTRL_RESET, softRst: 1'b0, hour12: 1'b0,
                sec: TIME_RESET, min: TIME_RESET, hour: TIME_RESET,
                upd: UPD_RUN, ack: 1'b0, timeEv: 1'b0, calendar_event_flag: 1'b0,
                dayRoll: 1'b0, calCheck: 1'b0, calHalt: 1'b0,
                rdData: 8'h00};
        end else begin
            s_reg <= s_next;
        end
    end

    assign regRdData = s_reg.rdData;
    assign updateAck = s_reg.ack;
    assign timeEventFlag = s_reg.timeEv;
    assign calendarEventFlag = s_reg.calendar_event_flag;
    assign dayRollover = s_reg.dayRoll;
    assign calendarHalted = s_reg.calHalt;
endmodule

// *** rtl/rtc_pkg.sv ***
// Shared constants and types of the time-of-day block.
// Assumes one 200 MHz clock and a 32 kHz tick that arrives as an enable.
package rtc_pkg;

    // Register offsets on the host register port
    localparam logic [7:0] OFS_CONTROL = 8'h40;
    localparam logic [7:0] OFS_SOFT_RESET = 8'h41;
    localparam logic [7:0] OFS_HOUR_FORMAT = 8'h44;
    localparam logic [7:0] OFS_SECONDS = 8'h48;
    localparam logic [7:0] OFS_MINUTES = 8'h49;
    localparam logic [7:0] OFS_HOURS = 8'h4a;
    localparam logic [7:0] OFS_STATUS = 8'h58;

    // Field positions
    localparam int CTRL_TIME_REQ_BIT = 0;
    localparam int CTRL_CAL_REQ_BIT = 1;
    localparam int CTRL_TIME_SEL_LSB = 4;
    localparam int CTRL_CAL_SEL_LSB = 6;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hf3;
    localparam int SOFT_RESET_BIT = 7;
    localparam int HOUR_FORMAT_BIT = 0;
    localparam int MERIDIEM_BIT = 6;
    localparam int STAT_ACK_BIT = 0;
    localparam int STAT_TIME_EV_BIT = 1;
    localparam int STAT_CAL_EV_BIT = 2;

    // Reset values and BCD landmarks
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [6:0] TIME_RESET = 7'h00;
    localparam logic [6:0] BCD_LAST_MIN_SEC = 7'h59;
    localparam logic [5:0] BCD_LAST_HOUR_24 = 6'h23;
    localparam logic [5:0] BCD_NOON = 6'h12;
    localparam logic [5:0] BCD_ONE = 6'h01;
    localparam logic [5:0] BCD_ELEVEN = 6'h11;
    localparam logic [3:0] BCD_NINE = 4'h9;

    // Time base
    localparam int OSC_HZ = 32768;

    // Event select codes
    localparam logic [1:0] TSEL_MINUTE = 2'b00;
    localparam logic [1:0] TSEL_HOUR = 2'b01;
    localparam logic [1:0] TSEL_MIDNIGHT = 2'b10;
    localparam logic [1:0] TSEL_NOON = 2'b11;
    localparam logic [1:0] CSEL_WEEK = 2'b00;
    localparam logic [1:0] CSEL_MONTH = 2'b01;

    typedef enum logic [2:0] {
        UPD_RUN = 3'b001,
        UPD_WAIT = 3'b010,
        UPD_HALT = 3'b100
    } upd_e;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic read;
        logic [7:0] wrData;
    } reg_req_s;

    // Clear pulses from the status block
    typedef struct packed {
        logic ack;
        logic timeEvent;
        logic calEvent;
    } flag_clear_s;

    // Day landmarks reported by the calendar counter
    typedef struct packed {
        logic isMonday;
        logic firstOfMonth;
        logic firstOfJanuary;
    } cal_status_s;

endpackage

// *** rtl/rtc_second_divider.sv ***
// Divides the 32 kHz enable down to a one-second enable pulse.
// Assumes oscTick is a one-cycle pulse synchronous to clk.
module rtc_second_divider #(
    parameter int DIV = 32768
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hold,
    input wire logic oscTick,
    output logic secTick
);
    import rtc_pkg::*;

    typedef struct packed {
        logic [$clog2(DIV)-1:0] count;
        logic tick;
    } div_state_s;

    localparam logic [$clog2(DIV)-1:0] LAST = ($clog2(DIV))'(DIV - 1);

    div_state_s s_reg;
    div_state_s s_next;

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        // Held count restarts a full second on release
        if (hold) begin
            s_next.count = '0;
        end else if (oscTick) begin
            if (s_reg.count == LAST) begin
                s_next.count = '0;
                s_next.tick = 1'b1;
            end else begin
                s_next.count = s_reg.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign secTick = s_reg.tick;
endmodule

// *** verification/rtc_time_monitor.sv ***
// Checker for the time-of-day block, bound to its top module.
// Assumes the bench pulses oscTick every 4 cycles with 4 ticks a second.
module rtc_time_monitor
    import rtc_pkg::*;
#(
    parameter int OSC_TICKS_PER_SEC = OSC_HZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic oscTick,
    input wire rtc_pkg::reg_req_s regReq,
    input wire rtc_pkg::flag_clear_s flagClear,
    input wire rtc_pkg::cal_status_s calStatus,
    input wire logic [7:0] regRdData,
    input wire logic updateAck,
    input wire logic timeEventFlag,
    input wire logic calendarEventFlag,
    input wire logic dayRollover,
    input wire logic calendarHalted
);
    timeunit 1ns;
    timeprecision 100ps;
    // One second of 16 cycles plus margin; too short for a real divider
    localparam int ACK_MAX = 40;
    logic [1:0] reqBits_reg;
    logic softOn_reg;
    logic wrCtrl;
    logic wrSoft;
    logic rdSec;
    assign wrCtrl = regReq.write && regReq.addr == OFS_CONTROL;
    assign wrSoft = regReq.write && regReq.addr == OFS_SOFT_RESET;
    assign rdSec = regReq.read && regReq.addr == OFS_SECONDS;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            softOn_reg <= 1'b0;
        end else if (wrSoft) begin
            softOn_reg <= regReq.wrData[SOFT_RESET_BIT];
        end
        if (!rst_n || softOn_reg) begin
            reqBits_reg <= 2'h0;
        end else if (wrCtrl) begin
            reqBits_reg <= regReq.wrData[1:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ack_bound;
        wrCtrl && regReq.wrData[0] && !updateAck && !softOn_reg
            |-> ##[1:ACK_MAX] updateAck;
    endproperty
    a_ack_bound: assert property (p_ack_bound)
        else $error("acknowledge late");
    property p_ack_req;
        $rose(updateAck) |-> reqBits_reg != 2'h0;
    endproperty
    a_ack_req: assert property (p_ack_req)
        else $error("acknowledge without request");
    property p_ack_drop;
        wrCtrl && regReq.wrData[1:0] == 2'h0 && updateAck |-> ##2 !updateAck;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("acknowledge kept after resume");
    property p_cal_halt;
        $rose(calendarHalted) |-> reqBits_reg[1];
    endproperty
    a_cal_halt: assert property (p_cal_halt)
        else $error("calendar halted unasked");
    property p_ctrl_rsvd;
        regReq.read && regReq.addr == OFS_CONTROL |=> regRdData[3:2] == 2'h0;
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd)
        else $error("control reserved bits set");
    property p_soft;
        softOn_reg && $past(softOn_reg)
            |-> !updateAck && !timeEventFlag && !calendarEventFlag;
    endproperty
    a_soft: assert property (p_soft)
        else $error("flags alive in soft reset");
    property p_sec;
        rdSec |=> !regRdData[7] && regRdData[3:0] <= BCD_NINE
            && regRdData[6:4] <= 3'h5;
    endproperty
    a_sec: assert property (p_sec)
        else $error("seconds not BCD 0-59");
    property p_min;
        regReq.read && regReq.addr == OFS_MINUTES |=> !regRdData[7]
            && regRdData[3:0] <= BCD_NINE && regRdData[6:4] <= 3'h5;
    endproperty
    a_min: assert property (p_min)
        else $error("minutes not BCD 0-59");
    property p_hour;
        regReq.read && regReq.addr == OFS_HOURS |=> !regRdData[7]
            && regRdData[3:0] <= BCD_NINE && regRdData[5:4] <= 2'h2;
    endproperty
    a_hour: assert property (p_hour)
        else $error("hours not BCD");
    property p_day;
        dayRollover |=> !dayRollover;
    endproperty
    a_day: assert property (p_day)
        else $error("rollover longer than a cycle");
    c_halt: cover property (updateAck && calendarHalted);
    c_tev: cover property ($rose(timeEventFlag));
    c_cev: cover property ($rose(calendarEventFlag));
endmodule

bind rtc_time_control_and_counters rtc_time_monitor #(
    .OSC_TICKS_PER_SEC(OSC_TICKS_PER_SEC)
) i_mon (
    .clk(clk), .rst_n(rst_n), .oscTick(oscTick), .regReq(regReq),
    .flagClear(flagClear), .calStatus(calStatus), .regRdData(regRdData),
    .updateAck(updateAck), .timeEventFlag(timeEventFlag),
    .calendarEventFlag(calendarEventFlag), .dayRollover(dayRollover),
    .calendarHalted(calendarHalted)
);

// *** verification/rtc_time_control_and_counters_test.sv ***
// Self-checking bench for the time-of-day block.
// Assumes the bench makes the 32 kHz enable, one pulse every 4 cycles.
module rtc_time_control_and_counters_test;
    timeunit 1ns;
    timeprecision 100ps;
    import rtc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic oscTick = 1'b0;
    logic [1:0] oscCnt = 2'h0;
    reg_req_s regReq = '0;
    flag_clear_s flagClear = '0;
    cal_status_s calStatus = '0;
    logic [7:0] regRdData, rdv;
    logic updateAck, timeEventFlag, calendarEventFlag;
    logic dayRollover, calendarHalted;
    int errorCnt = 0;
    int nCompared = 0;
    `define CHK(got, exp) begin \
        nCompared++; \
        if ((got) !== (exp)) begin \
            errorCnt++; \
            $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
        end \
    end

    rtc_time_control_and_counters #(.OSC_TICKS_PER_SEC(4)) i_dut (
        .clk(clk), .rst_n(rst_n), .oscTick(oscTick), .regReq(regReq),
        .flagClear(flagClear), .calStatus(calStatus), .regRdData(regRdData),
        .updateAck(updateAck), .timeEventFlag(timeEventFlag),
        .calendarEventFlag(calendarEventFlag), .dayRollover(dayRollover),
        .calendarHalted(calendarHalted)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    always @(negedge clk) begin
        oscCnt <= oscCnt + 2'h1;
        oscTick <= (oscCnt == 2'h3);
    end

    task automatic wrapUp();
        $display("compared %0d mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        regReq.addr = addr;
        regReq.wrData = data;
        regReq.write = 1'b1;
        @(negedge clk);
        regReq.write = 1'b0;
    endtask

    task automatic rd(input logic [7:0] addr);
        @(negedge clk);
        regReq.addr = addr;
        regReq.read = 1'b1;
        @(negedge clk);
        regReq.read = 1'b0;
        rdv = regRdData;
    endtask

    task automatic waitAck();
        int n = 0;
        while (updateAck !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (updateAck !== 1'b1) begin
            errorCnt++;
            $display("[FAIL] %0t no acknowledge", $time);
            wrapUp();
        end
    endtask

    // Sets h:m:59 while halted, resumes, checks one second later
    task automatic round(input logic [7:0] ctl, input logic [7:0] h,
        input logic [7:0] m, input logic [2:0] cal, input logic [7:0] eh,
        input logic [7:0] em, input logic et, input logic ec);
        calStatus = cal;
        wr(OFS_CONTROL, ctl | 8'h03);
        waitAck();
        `CHK(calendarHalted, 1'b1);
        wr(OFS_SECONDS, 8'h59);
        wr(OFS_MINUTES, m);
        wr(OFS_HOURS, h);
        @(negedge clk);
        flagClear = 3'h3;
        @(negedge clk);
        flagClear = '0;
        wr(OFS_CONTROL, ctl);
        @(negedge clk);
        `CHK(updateAck, 1'b0);
        // Calendar flag lands three cycles after the rollover tick
        repeat (19) @(negedge clk);
        `CHK(timeEventFlag, et);
        `CHK(calendarEventFlag, ec);
        rd(OFS_SECONDS);
        `CHK(rdv, 8'h00);
        rd(OFS_MINUTES);
        `CHK(rdv, em);
        rd(OFS_HOURS);
        `CHK(rdv, eh);
        rd(OFS_STATUS);
        `CHK(rdv, {5'h00, ec, et, 1'b0});
    endtask

    initial begin
        static logic [7:0] regMap[6] = '{OFS_CONTROL, OFS_SOFT_RESET,
            OFS_HOUR_FORMAT, OFS_SECONDS, OFS_MINUTES, OFS_HOURS};
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        foreach (regMap[i]) begin
            rd(regMap[i]);
            `CHK(rdv, 8'h00);
        end
        wr(8'h42, 8'hff);
        rd(8'h42);
        `CHK(rdv, 8'h00);
        wr(OFS_CONTROL, 8'hfc);
        rd(OFS_CONTROL);
        `CHK(rdv, 8'hf0);
        wr(OFS_CONTROL, 8'h01);
        waitAck();
        @(negedge clk);
        flagClear = 3'h4;
        @(negedge clk);
        flagClear = '0;
        `CHK(updateAck, 1'b0);
        wr(OFS_CONTROL, 8'h00);
        round(8'h00, 8'h00, 8'h00, 3'h4, 8'h00, 8'h01, 1'b1, 1'b0);
        round(8'h10, 8'h00, 8'h00, 3'h0, 8'h00, 8'h01, 1'b0, 1'b0);
        round(8'h10, 8'h00, 8'h59, 3'h0, 8'h01, 8'h00, 1'b1, 1'b0);
        round(8'h20, 8'h23, 8'h59, 3'h4, 8'h00, 8'h00, 1'b1, 1'b1);
        round(8'h20, 8'h11, 8'h59, 3'h4, 8'h12, 8'h00, 1'b0, 1'b0);
        round(8'h30, 8'h11, 8'h59, 3'h4, 8'h12, 8'h00, 1'b1, 1'b0);
        round(8'h40, 8'h23, 8'h59, 3'h4, 8'h00, 8'h00, 1'b1, 1'b0);
        round(8'h60, 8'h23, 8'h59, 3'h2, 8'h00, 8'h00, 1'b1, 1'b1);
        round(8'h90, 8'h23, 8'h59, 3'h1, 8'h00, 8'h00, 1'b1, 1'b1);
        round(8'hd0, 8'h23, 8'h59, 3'h1, 8'h00, 8'h00, 1'b1, 1'b1);
        wr(OFS_HOUR_FORMAT, 8'h01);
        rd(OFS_HOUR_FORMAT);
        `CHK(rdv, 8'h01);
        round(8'h00, 8'h11, 8'h59, 3'h0, 8'h52, 8'h00, 1'b1, 1'b0);
        round(8'h20, 8'h51, 8'h59, 3'h4, 8'h12, 8'h00, 1'b1, 1'b1);
        round(8'h00, 8'h52, 8'h59, 3'h0, 8'h41, 8'h00, 1'b1, 1'b0);
        wr(OFS_CONTROL, 8'h30);
        wr(OFS_SOFT_RESET, 8'h80);
        repeat (3) @(negedge clk);
        rd(OFS_SOFT_RESET);
        `CHK(rdv, 8'h80);
        rd(OFS_CONTROL);
        `CHK(rdv, 8'h00);
        rd(OFS_HOUR_FORMAT);
        `CHK(rdv, 8'h00);
        rd(OFS_SECONDS);
        `CHK(rdv, 8'h00);
        `CHK(timeEventFlag, 1'b0);
        wr(OFS_SOFT_RESET, 8'h00);
        rd(OFS_SOFT_RESET);
        `CHK(rdv, 8'h00);
        wrapUp();
    end
endmodule
